// ===== common/mgmt_cfg.svh
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH
// ==========================================
// Register indices (byte address = 4 * index)
`define IDX_STATUS_CHANGE 4'h4
`define IDX_IRQ_CONFIG 4'h5
`define IDX_WINDOW_ENABLE 4'h6
`define IDX_SOCKET_MODE 4'h8
`define IDX_EVENT_STATUS 4'h9
`define IDX_EVENT_MASK 4'ha
`define IDX_WINDOW_HIT 4'hb
// ==========================================
// Field positions
`define BIT_BATT_DEAD 0
`define BIT_BATT_WARN 1
`define BIT_READY 2
`define BIT_CARD_DET 3
`define ROUTE_LSB 4
`define WEN_RSVD_BIT 5
`define MODE_IO_BIT 0
`define MODE_LEGACY_BIT 1
// ==========================================
// Reset values and masks
`define RST_IRQ_CONFIG 8'h00
`define RST_WINDOW_ENABLE 8'h00
`define RST_SOCKET_MODE 8'h00
`define RST_EVENT_MASK 4'h0
`define WEN_WRITE_MASK 8'hdf
// ==========================================
// Routing codes
`define ROUTE_OFF 4'h0
`define ROUTE_IRQ14 4'he
`define ROUTE_IRQ15 4'hf
`endif

// ===== common/mgmt_pkg.sv
package mgmt_pkg;
    typedef struct packed {
        logic card_detect_first;
        logic card_detect_second;
        logic card_ready_pin;
        logic battery_warn_pin;
        logic battery_dead_status_pin;
    } card_pins_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avl_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avl_rsp_t;

    typedef struct packed {
        logic [4:0] mem_hit;
        logic [1:0] io_hit;
    } window_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;
endpackage

// ===== dv/card_socket_model.sv
`timescale 1ns/10ps
// ==========================================
// Card socket model: the pins a card presents to the socket
module card_socket_model
    import mgmt_pkg::*;
(
    input wire logic clk,
    input mgmt_pkg::card_pins_t target,
    output mgmt_pkg::card_pins_t pins
);
    // Levels move just after an edge, so the sampler never sees a race
    always_ff @(posedge clk) begin
        pins <= target;
    end
endmodule

// ===== dv/tb_socket_mgmt_irq_and_window_enable.sv
`timescale 1ns/10ps
`include "mgmt_cfg.svh"
module tb_socket_mgmt_irq_and_window_enable;
    import mgmt_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    card_pins_t target = 5'h1f;
    card_pins_t pins;
    card_pins_t p;
    logic [4:0] mem_in_range = 5'h00;
    logic [1:0] io_in_range = 2'h0;
    logic [15:0] irq_lines;
    window_req_t window_hit;
    logic irq;
    logic [31:0] rd;
    logic [7:0] w;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'h93b2;

    always #20 clk = ~clk;

    card_socket_model i_card (.clk(clk), .target(target), .pins(pins));

    socket_mgmt i_dut (
        .clk(clk),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .pins(pins),
        .mem_in_range(mem_in_range),
        .io_in_range(io_in_range),
        .irq_lines(irq_lines),
        .window_hit(window_hit),
        .irq(irq)
    );

    // ==========================================
    // Expectations
    function automatic logic [3:0] exp_flags(card_pins_t o, card_pins_t n,
                                              logic io);
        logic [3:0] f;
        f[0] = io ? (o.battery_dead_status_pin != n.battery_dead_status_pin)
                  : (o.battery_dead_status_pin & ~n.battery_dead_status_pin);
        f[1] = !io && o.battery_warn_pin && !n.battery_warn_pin;
        f[2] = !io && (o.card_ready_pin != n.card_ready_pin);
        f[3] = (o.card_detect_first != n.card_detect_first) ||
               (o.card_detect_second != n.card_detect_second);
        return f;
    endfunction

    function automatic logic [15:0] exp_lines(logic [3:0] code, logic act);
        logic [15:0] v;
        v = 16'h0000;
        // Reserved codes and zero leave every line low
        if (act && code inside {3, 4, 5, 7, 9, 10, 11, 12, 14, 15}) begin
            v[code] = 1'b1;
        end
        return v;
    endfunction

    // ==========================================
    // Checking and closing
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ==========================================
    // Avalon master: hold until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            miscompares++;
            final_report();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    // ==========================================
    // One pin event through flags, routing, status and mask
    task automatic run_event(input logic [3:0] code, input logic [3:0] en,
                             input logic io, input logic [3:0] mask,
                             input card_pins_t nxt);
        logic [3:0] f;
        logic [15:0] e;
        f = exp_flags(pins, nxt, io);
        bus(1'b1, `IDX_SOCKET_MODE, {31'h0, io});
        bus(1'b1, `IDX_IRQ_CONFIG, {24'h0, code, en});
        bus(1'b1, `IDX_EVENT_MASK, {28'h0, mask});
        bus(1'b0, `IDX_STATUS_CHANGE, 32'h0);
        bus(1'b1, `IDX_EVENT_STATUS, 32'hf);
        target <= nxt;
        repeat (6) @(posedge clk);
        e = exp_lines(code, |(f & en));
        chk(irq_lines, e);
        chk(irq, |(f & mask));
        bus(1'b0, `IDX_IRQ_CONFIG, 32'h0);
        chk(rd, {24'h0, code, en});
        bus(1'b0, `IDX_EVENT_STATUS, 32'h0);
        chk(rd, {28'h0, f});
        bus(1'b1, `IDX_EVENT_STATUS, {28'h0, f});
        bus(1'b0, `IDX_EVENT_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(irq, 1'b0);
        bus(1'b0, `IDX_STATUS_CHANGE, 32'h0);
        chk(rd, {28'h0, f});
        repeat (3) @(posedge clk);
        chk(irq_lines, 16'h0000);
        bus(1'b0, `IDX_STATUS_CHANGE, 32'h0);
        chk(rd, 32'h0);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, `IDX_IRQ_CONFIG, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, `IDX_WINDOW_ENABLE, 32'h0);
        chk(rd, 32'h0);
        // Unmapped place: writes vanish, reads give zero
        bus(1'b1, 4'h3, 32'hff);
        bus(1'b0, 4'h3, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 8'hff : 8'($random(seed));
            mem_in_range <= 5'($random(seed));
            io_in_range <= 2'($random(seed));
            bus(1'b1, `IDX_WINDOW_ENABLE, {24'h0, w});
            bus(1'b0, `IDX_WINDOW_ENABLE, 32'h0);
            chk(rd, {24'h0, w & 8'hdf});
            repeat (2) @(posedge clk);
            chk(window_hit,
                {mem_in_range & w[4:0], io_in_range & w[7:6]});
            bus(1'b0, `IDX_WINDOW_HIT, 32'h0);
            chk(rd,
                {25'h0, io_in_range & w[7:6], mem_in_range & w[4:0]});
        end
        for (int i = 0; i < 40; i++) begin
            p = 5'($random(seed));
            if (i < 20) begin
                p = ~pins;
            end
            run_event(i[3:0], (i < 16) ? 4'hf : (i < 20) ? 4'(1 << (i - 16))
                      : 4'($random(seed)), (i > 19) && seed[3],
                      4'($random(seed)), p);
        end
        // Legacy bit set: flags still latch, no line may rise
        bus(1'b1, `IDX_SOCKET_MODE, 32'h2);
        bus(1'b1, `IDX_IRQ_CONFIG, 32'h9f);
        bus(1'b0, `IDX_STATUS_CHANGE, 32'h0);
        target <= pins ^ 5'h10;
        repeat (6) @(posedge clk);
        chk(irq_lines, 16'h0000);
        bus(1'b0, `IDX_STATUS_CHANGE, 32'h0);
        chk(rd, 32'h8);
        // Ready change caught in memory mode, then io mode hides it
        bus(1'b1, `IDX_SOCKET_MODE, 32'h0);
        target <= pins ^ 5'h04;
        repeat (4) @(posedge clk);
        bus(1'b1, `IDX_SOCKET_MODE, 32'h1);
        bus(1'b0, `IDX_STATUS_CHANGE, 32'h0);
        chk(rd, 32'h0);
        final_report();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule

// ===== rtl/irq_router.sv
`timescale 1ns/10ps
`include "mgmt_cfg.svh"
module irq_router (
    input wire logic [3:0] route,
    input wire logic active,
    output logic [15:0] lines
);
    function automatic logic route_valid(input logic [3:0] code);
        case (code)
            4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc: route_valid = 1'b1;
            `ROUTE_IRQ14, `ROUTE_IRQ15: route_valid = 1'b1;
            default: route_valid = 1'b0;
        endcase
    endfunction

    // Reserved and disabled codes drive no line
    always_comb begin
        lines = 16'h0000;
        if (active && route_valid(route)) begin
            lines[route] = 1'b1;
        end
    end
endmodule

// ===== rtl/pin_change_detect.sv
`timescale 1ns/10ps
`include "mgmt_cfg.svh"
module pin_change_detect
    import mgmt_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input mgmt_pkg::card_pins_t pins,
    input wire logic io_mode,
    output logic [3:0] change
);
    card_pins_t prev_r;
    logic armed_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_r <= '0;
            armed_r <= 1'b0;
        end else begin
            prev_r <= pins;
            armed_r <= 1'b1;
        end
    end

    // No edges before the first sample, avoids a false change at reset
    always_comb begin
        change = 4'h0;
        if (armed_r) begin
            change[`BIT_BATT_DEAD] = io_mode ?
                (pins.battery_dead_status_pin
                 != prev_r.battery_dead_status_pin) :
                (prev_r.battery_dead_status_pin
                 && !pins.battery_dead_status_pin);
            change[`BIT_BATT_WARN] = !io_mode &&
                prev_r.battery_warn_pin && !pins.battery_warn_pin;
            change[`BIT_READY] = !io_mode &&
                (pins.card_ready_pin != prev_r.card_ready_pin);
            change[`BIT_CARD_DET] =
                (pins.card_detect_first != prev_r.card_detect_first) ||
                (pins.card_detect_second
                 != prev_r.card_detect_second);
        end
    end
endmodule

// ===== rtl/socket_mgmt.sv
//
// Operation
// - Battery dead/status change flag with enable bit 0 raises interrupt
// - Battery warning change flag with enable bit 1 raises interrupt in memory mode only
// - Ready change flag with enable bit 2 raises interrupt
// - Card detect change flag with enable bit 3 raises interrupt
// - Bits 7-4 route interrupt; zero and reserved codes drive nothing
// - Code 1110 selects the IRQ14 output
// - Code 1111 selects the IRQ15 output
// - Memory window n decodes only while enable bit n set
// - I/O windows 0 and 1 decode only with bits 6, 7
// - Reading status change register clears all change flags except those set by a change in the same cycle
// - Detect pins set card detect change; ready change only memory mode
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "mgmt_cfg.svh"
module socket_mgmt
    import mgmt_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input mgmt_pkg::card_pins_t pins,
    input wire logic [4:0] mem_in_range,
    input wire logic [1:0] io_in_range,
    output logic [15:0] irq_lines,
    output mgmt_pkg::window_req_t window_hit,
    output logic irq
);
    import mgmt_pkg::*;

    // ==========================================
    // Registers
    logic [3:0] status_change_r;
    logic [7:0] status_irq_config_r;
    logic [7:0] window_enable_r;
    logic [7:0] socket_mode_r;
    logic [3:0] event_status_r;
    logic [3:0] event_mask_r;
    logic [31:0] readdata_nxt;
    logic [3:0] change;
    logic [15:0] lines_nxt;
    logic mgmt_active;
    bus_state_t bus_r;
    logic take;
    logic rd_status;

    // Answer one cycle after the request; waitrequest high while idle
    assign take = (avs_read || avs_write) && bus_r == BUS_IDLE;
    assign rd_status = take && avs_read &&
        avs_address == `IDX_STATUS_CHANGE;

    pin_change_detect u_detect (
        .clk(clk),
        .reset_n(reset_n),
        .pins(pins),
        .io_mode(socket_mode_r[`MODE_IO_BIT]),
        .change(change)
    );

    // ==========================================
    // Bus handshake
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bus_r <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            unique case (bus_r)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_r <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= readdata_nxt;
                    end
                end
                BUS_ACK: begin
                    bus_r <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_r <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        readdata_nxt = 32'h00000000;
        case (avs_address)
            `IDX_STATUS_CHANGE: readdata_nxt[3:0] = status_change_r;
            `IDX_IRQ_CONFIG: readdata_nxt[7:0] = status_irq_config_r;
            `IDX_WINDOW_ENABLE:
                readdata_nxt[7:0] = window_enable_r & `WEN_WRITE_MASK;
            `IDX_SOCKET_MODE: readdata_nxt[7:0] = socket_mode_r;
            `IDX_EVENT_STATUS: readdata_nxt[3:0] = event_status_r;
            `IDX_EVENT_MASK: readdata_nxt[3:0] = event_mask_r;
            `IDX_WINDOW_HIT:
                readdata_nxt[6:0] = {window_hit.io_hit, window_hit.mem_hit};
            default: readdata_nxt = 32'h00000000;
        endcase
    end

    // ==========================================
    // Software-written registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_irq_config_r <= `RST_IRQ_CONFIG;
            window_enable_r <= `RST_WINDOW_ENABLE;
            socket_mode_r <= `RST_SOCKET_MODE;
            event_mask_r <= `RST_EVENT_MASK;
        end else if (take && avs_write) begin
            case (avs_address)
                `IDX_IRQ_CONFIG: status_irq_config_r <= avs_writedata[7:0];
                `IDX_WINDOW_ENABLE:
                    window_enable_r <= avs_writedata[7:0]
                        & `WEN_WRITE_MASK;
                `IDX_SOCKET_MODE: socket_mode_r <= avs_writedata[7:0];
                `IDX_EVENT_MASK: event_mask_r <= avs_writedata[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Change flags: a new change wins over the clearing read
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_change_r <= 4'h0;
        end else begin
            // Ready flag held clear in io mode so it always reads zero
            status_change_r <= ((rd_status ? 4'h0 : status_change_r)
                | change) & ~(4'(socket_mode_r[`MODE_IO_BIT])
                << `BIT_READY);
        end
    end

    // Sticky event status, write one to clear; set wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            event_status_r <= 4'h0;
        end else begin
            event_status_r <= (event_status_r &
                ~((take && avs_write && avs_address == `IDX_EVENT_STATUS) ?
                  avs_writedata[3:0] : 4'h0)) | change;
        end
    end

    // ==========================================
    // Management interrupt
    always_comb begin
        mgmt_active =
            (status_change_r[`BIT_BATT_DEAD] &&
             status_irq_config_r[`BIT_BATT_DEAD]) ||
            (status_change_r[`BIT_BATT_WARN] &&
             status_irq_config_r[`BIT_BATT_WARN] &&
             !socket_mode_r[`MODE_IO_BIT]) ||
            (status_change_r[`BIT_READY] &&
             status_irq_config_r[`BIT_READY]) ||
            (status_change_r[`BIT_CARD_DET] &&
             status_irq_config_r[`BIT_CARD_DET]);
        // Legacy bit set by software silences irq_lines; irq still follows event status and mask
        if (socket_mode_r[`MODE_LEGACY_BIT]) begin
            mgmt_active = 1'b0;
        end
    end

    irq_router u_router (
        .route(status_irq_config_r[7:`ROUTE_LSB]),
        .active(mgmt_active),
        .lines(lines_nxt)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_lines <= 16'h0000;
            irq <= 1'b0;
        end else begin
            irq_lines <= lines_nxt;
            irq <= |(event_status_r & event_mask_r);
        end
    end

    // ==========================================
    // Window decode enables
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            window_hit <= '0;
        end else begin
            window_hit.mem_hit <= mem_in_range & window_enable_r[4:0];
            window_hit.io_hit <= io_in_range & window_enable_r[7:6];
        end
    end

    // ==========================================
    // Checks
    a_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
        rd_status && change == 4'h0 |=> status_change_r == 4'h0)
        else $error("status flags not cleared by read");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
        window_enable_r[`WEN_RSVD_BIT] == 1'b0)
        else $error("reserved window bit set");
    a_cd_enable: assert property (@(posedge clk) disable iff (!reset_n)
        status_change_r[3] && status_irq_config_r[3] && !socket_mode_r[1]
        && status_irq_config_r[7:4] == 4'h9 |=> irq_lines[9])
        else $error("card detect interrupt missing");
    a_bd_enable: assert property (@(posedge clk) disable iff (!reset_n)
        status_change_r[0] && status_irq_config_r[0] && !socket_mode_r[1]
        && status_irq_config_r[7:4] == 4'h3 |=> irq_lines[3])
        else $error("battery dead interrupt missing");
    a_no_enable: assert property (@(posedge clk) disable iff (!reset_n)
        status_irq_config_r[3:0] == 4'h0 |=> irq_lines == 16'h0000)
        else $error("interrupt without enable");
    a_route_off: assert property (@(posedge clk) disable iff (!reset_n)
        status_irq_config_r[7:4] == 4'h0 |=> irq_lines == 16'h0000)
        else $error("disabled route drives a line");
    a_route_14: assert property (@(posedge clk) disable iff (!reset_n)
        mgmt_active && status_irq_config_r[7:4] == 4'he
        |=> irq_lines == 16'h4000)
        else $error("code 1110 not on line 14");
    a_route_15: assert property (@(posedge clk) disable iff (!reset_n)
        mgmt_active && status_irq_config_r[7:4] == 4'hf
        |=> irq_lines == 16'h8000)
        else $error("code 1111 not on line 15");
    a_mem_gate: assert property (@(posedge clk) disable iff (!reset_n)
        !window_enable_r[0] |=> !window_hit.mem_hit[0])
        else $error("memory window 0 hit while disabled");
    a_io_gate: assert property (@(posedge clk) disable iff (!reset_n)
        io_in_range[1] && window_enable_r[7] |=> window_hit.io_hit[1])
        else $error("io window 1 missed");
    a_ready_io: assert property (@(posedge clk) disable iff (!reset_n)
        socket_mode_r[0] |=> status_change_r[2] == 1'b0)
        else $error("ready change in io mode");
    a_legacy_mute: assert property (@(posedge clk) disable iff (!reset_n)
        socket_mode_r[`MODE_LEGACY_BIT] |=> irq_lines == 16'h0000)
        else $error("interrupt line high with legacy bit set");

    c_irq_raised: cover property (@(posedge clk) $rose(|irq_lines));
    c_read_clear: cover property (@(posedge clk) rd_status
        && status_change_r != 4'h0);
    c_event_irq: cover property (@(posedge clk) $rose(irq));
endmodule
